//--- verilog/csc_pkg.sv
package csc_pkg;

    // ----------------------------------------------------------------
    // Session states, commands, instructions and status codes
    // ----------------------------------------------------------------

    // Session state of the receiver side.
    typedef enum logic [1:0] {
        CSC_IDLE   = 2'b00,
        CSC_CALLIN = 2'b01,
        CSC_COMM   = 2'b10
    } csc_state_t;

    // Command issued by the receiver to the card.
    typedef enum logic [1:0] {
        CSC_CMD_NONE    = 2'b00,
        CSC_CMD_REPORT  = 2'b01,
        CSC_CMD_CENTER  = 2'b10,
        CSC_CMD_REQDATA = 2'b11
    } csc_cmd_t;

    // Instruction field carried by a card response.
    localparam logic [1:0] CSC_INS_NONE       = 2'h0;
    localparam logic [1:0] CSC_INS_START      = 2'h1;
    localparam logic [1:0] CSC_INS_DISCONNECT = 2'h2;

    // Connection status carried by a report command.
    localparam logic [1:0] CSC_ST_NONE         = 2'h0;
    localparam logic [1:0] CSC_ST_CONNECTED    = 2'h1;
    localparam logic [1:0] CSC_ST_FAILED       = 2'h2;
    localparam logic [1:0] CSC_ST_DISCONNECTED = 2'h3;

    // Protocol unit index width and special values.
    localparam int         CSC_UNIT_W     = 8;
    localparam logic [7:0] CSC_UNIT_NONE  = 8'h00;
    localparam logic [7:0] CSC_UNIT_FIRST = 8'h01;
    localparam logic [7:0] CSC_UNIT_STEP  = 8'h01;

endpackage

//--- verilog/csc_unit_tracker.sv
`timescale 1ns/1ps
module csc_unit_tracker
    import csc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       firstReply,
    input  wire logic       advance,
    input  wire logic [7:0] unitIndex,
    input  wire logic [7:0] finalIndex,
    output logic            isLast,
    output logic            isError,
    output logic [7:0]      nextIndex
);

    // ----------------------------------------------------------------
    // Expected unit index
    // ----------------------------------------------------------------

    logic [7:0] expected_ff;     // Index expected in the next data reply.
    logic [7:0] nxt_expected;    // Next value of the expected index.
    logic [7:0] expNow;          // Index expected for the reply in hand.

    // The first reply of a block restarts the count at the first unit.
    always_comb begin
        expNow       = firstReply ? CSC_UNIT_FIRST : expected_ff;
        isLast       = (unitIndex == finalIndex);
        isError      = (unitIndex != expNow);
        nextIndex    = expNow + CSC_UNIT_STEP;
        nxt_expected = advance ? nextIndex : expected_ff;
    end

    // Registers the expected index.
    always_ff @(posedge clk) begin
        if (reset) begin
            expected_ff <= CSC_UNIT_FIRST;
        end else begin
            expected_ff <= nxt_expected;
        end
    end

endmodule

//--- verilog/csc_controller.sv
`timescale 1ns/1ps
module csc_controller
    import csc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       cardRespValid,
    input  wire logic [1:0] cardInstr,
    input  wire logic [7:0] respUnitIndex,
    input  wire logic [7:0] respFinalIndex,
    input  wire logic       modemConnected,
    input  wire logic       modemBusy,
    input  wire logic       cardError,
    input  wire logic       cardAbsent,
    input  wire logic       lineFault,
    input  wire logic       carrierLost,
    input  wire logic       respTimeout,
    input  wire logic       centerTimeout,
    input  wire logic       centerDataValid,
    output csc_state_t      sessionState_ff,
    output logic            dialStart_ff,
    output logic            hangUp_ff,
    output logic            cmdValid_ff,
    output csc_cmd_t        cmdCode_ff,
    output logic [1:0]      cmdStatus_ff,
    output logic [7:0]      cmdUnitIndex_ff,
    output logic            forwardToCenter_ff,
    output logic            purchaseDisable_ff
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------

    logic       outstanding_ff;      // A command awaits its response.
    csc_cmd_t   lastCmd_ff;          // Kind of the command last issued.
    logic       pendValid_ff;        // A command waits to be issued.
    csc_cmd_t   pendCode_ff;         // Kind of the waiting command.
    logic [1:0] pendStatus_ff;       // Status carried by a waiting report.
    logic [7:0] pendUnit_ff;         // Unit index of a waiting request.

    csc_state_t nxt_sessionState;
    logic       nxt_dialStart;
    logic       nxt_hangUp;
    logic       nxt_forwardToCenter;
    logic       nxt_purchaseDisable;
    logic       nxt_pendValid;
    csc_cmd_t   nxt_pendCode;
    logic [1:0] nxt_pendStatus;
    logic [7:0] nxt_pendUnit;
    logic       nxt_cmdValid;
    csc_cmd_t   nxt_cmdCode;
    logic [1:0] nxt_cmdStatus;
    logic [7:0] nxt_cmdUnitIndex;
    logic       nxt_outstanding;
    csc_cmd_t   nxt_lastCmd;

    logic       discInstr;           // Card asks to disconnect the call.
    logic       startInstr;          // Card asks to start a call-in.
    logic       dataResp;            // Reply that carries protocol data.
    logic       unitLast;            // Reply holds the final unit.
    logic       unitErr;             // Reply holds an unexpected unit.
    logic [7:0] unitNext;            // Unit index to request next.
    logic       advanceUnit;         // Step the expected unit index.
    logic       commErr;             // Any error that ends communications.

    // ----------------------------------------------------------------
    // Event decode
    // ----------------------------------------------------------------

    // Instructions and data replies only count when a response arrives.
    always_comb begin
        discInstr  = cardRespValid && (cardInstr == CSC_INS_DISCONNECT);
        startInstr = cardRespValid && (cardInstr == CSC_INS_START);
        dataResp   = cardRespValid && ((lastCmd_ff == CSC_CMD_CENTER) || (lastCmd_ff == CSC_CMD_REQDATA));
        // A unit error only matters when the card announced several units.
        commErr    = cardError || cardAbsent || lineFault || carrierLost || respTimeout || centerTimeout
                     || (dataResp && (respFinalIndex != CSC_UNIT_NONE) && unitErr);
        advanceUnit = (sessionState_ff == CSC_COMM) && dataResp && !discInstr && !commErr;
    end

    // Tracks the unit index across a multi-part reply.
    csc_unit_tracker u_tracker (
        .clk        (clk),
        .reset      (reset),
        .firstReply (lastCmd_ff == CSC_CMD_CENTER),
        .advance    (advanceUnit),
        .unitIndex  (respUnitIndex),
        .finalIndex (respFinalIndex),
        .isLast     (unitLast),
        .isError    (unitErr),
        .nextIndex  (unitNext)
    );

    // ----------------------------------------------------------------
    // Session state machine
    // ----------------------------------------------------------------

    // Computes the next session state and the commands it queues.
    always_comb begin
        nxt_sessionState    = sessionState_ff;
        nxt_dialStart       = 1'b0;
        nxt_hangUp          = 1'b0;
        nxt_forwardToCenter = 1'b0;
        nxt_purchaseDisable = purchaseDisable_ff;
        nxt_pendValid       = pendValid_ff;
        nxt_pendCode        = pendCode_ff;
        nxt_pendStatus      = pendStatus_ff;
        nxt_pendUnit        = pendUnit_ff;
        // A waiting command leaves the slot once it is issued.
        if (pendValid_ff && !outstanding_ff) begin
            nxt_pendValid = 1'b0;
        end
        case (sessionState_ff)
            CSC_IDLE: begin
                // A disconnect instruction is ignored here.
                if (cardError || cardAbsent) begin
                    nxt_purchaseDisable = 1'b1;
                end else if (startInstr) begin
                    nxt_dialStart    = 1'b1;
                    nxt_sessionState = CSC_CALLIN;
                end
            end
            CSC_CALLIN: begin
                if (discInstr || cardError || cardAbsent) begin
                    nxt_hangUp       = 1'b1;
                    nxt_sessionState = CSC_IDLE;
                end else if (modemBusy || lineFault || carrierLost) begin
                    nxt_hangUp       = 1'b1;
                    nxt_pendValid    = 1'b1;
                    nxt_pendCode     = CSC_CMD_REPORT;
                    nxt_pendStatus   = CSC_ST_FAILED;
                    nxt_sessionState = CSC_IDLE;
                end else if (modemConnected) begin
                    nxt_pendValid       = 1'b1;
                    nxt_pendCode        = CSC_CMD_REPORT;
                    nxt_pendStatus      = CSC_ST_CONNECTED;
                    nxt_purchaseDisable = 1'b0;
                    nxt_sessionState    = CSC_COMM;
                end
            end
            CSC_COMM: begin
                if (discInstr) begin
                    nxt_hangUp       = 1'b1;
                    nxt_sessionState = CSC_IDLE;
                end else if (commErr) begin
                    nxt_hangUp       = 1'b1;
                    nxt_pendValid    = 1'b1;
                    nxt_pendCode     = CSC_CMD_REPORT;
                    nxt_pendStatus   = CSC_ST_DISCONNECTED;
                    nxt_sessionState = CSC_IDLE;
                end else if (dataResp) begin
                    // Forward once a single reply or the final unit is in.
                    if ((respFinalIndex == CSC_UNIT_NONE) || unitLast) begin
                        nxt_forwardToCenter = 1'b1;
                    end else begin
                        nxt_pendValid  = 1'b1;
                        nxt_pendCode   = CSC_CMD_REQDATA;
                        nxt_pendStatus = CSC_ST_NONE;
                        nxt_pendUnit   = unitNext;
                    end
                end else if (centerDataValid) begin
                    nxt_pendValid  = 1'b1;
                    nxt_pendCode   = CSC_CMD_CENTER;
                    nxt_pendStatus = CSC_ST_NONE;
                    nxt_pendUnit   = CSC_UNIT_NONE;
                end
            end
            default: begin
                nxt_sessionState = CSC_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Command issue
    // ----------------------------------------------------------------

    // Issues a waiting command only while no response is owed.
    always_comb begin
        nxt_cmdValid     = 1'b0;
        nxt_cmdCode      = cmdCode_ff;
        nxt_cmdStatus    = cmdStatus_ff;
        nxt_cmdUnitIndex = cmdUnitIndex_ff;
        nxt_lastCmd      = lastCmd_ff;
        nxt_outstanding  = outstanding_ff;
        if (cardRespValid || respTimeout) begin
            nxt_outstanding = 1'b0;
        end
        if (pendValid_ff && !outstanding_ff) begin
            nxt_cmdValid     = 1'b1;
            nxt_cmdCode      = pendCode_ff;
            nxt_cmdStatus    = pendStatus_ff;
            nxt_cmdUnitIndex = (pendCode_ff == CSC_CMD_REQDATA) ? pendUnit_ff : CSC_UNIT_NONE;
            nxt_lastCmd      = pendCode_ff;
            nxt_outstanding  = 1'b1;
        end
    end

    // Registers every piece of control state.
    always_ff @(posedge clk) begin
        if (reset) begin
            sessionState_ff    <= CSC_IDLE;
            dialStart_ff       <= 1'b0;
            hangUp_ff          <= 1'b0;
            forwardToCenter_ff <= 1'b0;
            purchaseDisable_ff <= 1'b0;
            pendValid_ff       <= 1'b0;
            pendCode_ff        <= CSC_CMD_NONE;
            pendStatus_ff      <= CSC_ST_NONE;
            pendUnit_ff        <= CSC_UNIT_NONE;
            cmdValid_ff        <= 1'b0;
            cmdCode_ff         <= CSC_CMD_NONE;
            cmdStatus_ff       <= CSC_ST_NONE;
            cmdUnitIndex_ff    <= CSC_UNIT_NONE;
            lastCmd_ff         <= CSC_CMD_NONE;
            outstanding_ff     <= 1'b0;
        end else begin
            sessionState_ff    <= nxt_sessionState;
            dialStart_ff       <= nxt_dialStart;
            hangUp_ff          <= nxt_hangUp;
            forwardToCenter_ff <= nxt_forwardToCenter;
            purchaseDisable_ff <= nxt_purchaseDisable;
            pendValid_ff       <= nxt_pendValid;
            pendCode_ff        <= nxt_pendCode;
            pendStatus_ff      <= nxt_pendStatus;
            pendUnit_ff        <= nxt_pendUnit;
            cmdValid_ff        <= nxt_cmdValid;
            cmdCode_ff         <= nxt_cmdCode;
            cmdStatus_ff       <= nxt_cmdStatus;
            cmdUnitIndex_ff    <= nxt_cmdUnitIndex;
            lastCmd_ff         <= nxt_lastCmd;
            outstanding_ff     <= nxt_outstanding;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Only the three legal states ever appear.
    property p_one_state;
        sessionState_ff inside {CSC_IDLE, CSC_CALLIN, CSC_COMM};
    endproperty
    a_one_state: assert property (p_one_state) else $error("Illegal session state.");
    // A start instruction while idle dials and enters call-in.
    property p_start_dial;
        (sessionState_ff == CSC_IDLE) && startInstr && !cardError && !cardAbsent
        |=> dialStart_ff && (sessionState_ff == CSC_CALLIN);
    endproperty
    a_start_dial: assert property (p_start_dial) else $error("Start instruction did not dial.");
    // A busy line queues a failed report and returns to idle.
    property p_busy_fail;
        (sessionState_ff == CSC_CALLIN) && modemBusy && !discInstr && !cardError && !cardAbsent
        |=> (sessionState_ff == CSC_IDLE) && pendValid_ff && (pendStatus_ff == CSC_ST_FAILED)
            ##[0:40] cmdValid_ff && (cmdStatus_ff == CSC_ST_FAILED);
    endproperty
    a_busy_fail: assert property (p_busy_fail) else $error("Failed call-in not reported.");
    // A middle unit requests the next unit and forwards nothing yet.
    property p_unit_more;
        (sessionState_ff == CSC_COMM) && dataResp && !discInstr && !commErr
        && (respFinalIndex != CSC_UNIT_NONE) && !unitLast
        |=> pendValid_ff && (pendCode_ff == CSC_CMD_REQDATA) && !forwardToCenter_ff
            && (pendUnit_ff == $past(respUnitIndex) + CSC_UNIT_STEP);
    endproperty
    a_unit_more: assert property (p_unit_more) else $error("Next unit not requested.");
    // Center data is queued to the card as a center-response command.
    property p_center_cmd;
        (sessionState_ff == CSC_COMM) && centerDataValid && !dataResp && !discInstr && !commErr
        |=> pendValid_ff && (pendCode_ff == CSC_CMD_CENTER);
    endproperty
    a_center_cmd: assert property (p_center_cmd) else $error("Center data not passed on.");
    // A disconnect while idle neither hangs up nor leaves the idle state.
    property p_idle_ignore;
        (sessionState_ff == CSC_IDLE) && discInstr |=> (sessionState_ff == CSC_IDLE) && !hangUp_ff;
    endproperty
    a_idle_ignore: assert property (p_idle_ignore) else $error("Idle disconnect not ignored.");
    // A disconnect during call-in or communications hangs up and goes idle.
    property p_comm_disc;
        (sessionState_ff != CSC_IDLE) && discInstr |=> hangUp_ff && (sessionState_ff == CSC_IDLE);
    endproperty
    a_comm_disc: assert property (p_comm_disc) else $error("Disconnect did not hang up.");
    // An error during communications reports disconnection and hangs up.
    property p_comm_err;
        (sessionState_ff == CSC_COMM) && commErr && !discInstr
        |=> hangUp_ff && (sessionState_ff == CSC_IDLE) && (pendStatus_ff == CSC_ST_DISCONNECTED);
    endproperty
    a_comm_err: assert property (p_comm_err) else $error("Communication error not handled.");
    // No new command while a response is still owed.
    property p_pairing;
        outstanding_ff && !cardRespValid && !respTimeout |=> !cmdValid_ff;
    endproperty
    a_pairing: assert property (p_pairing) else $error("Command issued before response.");
endmodule

//--- tb/csc_card_model.sv
`timescale 1ns/1ps
module csc_card_model
    import csc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       cmdValid,
    input  wire csc_cmd_t   cmdCode,
    input  wire logic [7:0] cmdUnitIndex,
    input  wire logic       kick,
    input  wire logic [1:0] kickInstr,
    input  wire logic [7:0] finalCfg,
    input  wire logic       badUnit,
    input  wire logic       slow,
    output logic            respValid,
    output logic [1:0]      instr,
    output logic [7:0]      unitIdx,
    output logic [7:0]      finalIdx
);
    // ------------------------------------------------------------
    // Card slave state
    // ------------------------------------------------------------
    logic       pend;  // A command waits for its one reply.
    logic [3:0] cnt;   // Cycles left before that reply.
    csc_cmd_t   codeR; // Kind of the waiting command.
    logic [7:0] reqR;  // Unit index that was asked for.
    logic [1:0] insR;  // Last instruction sent.
    logic [7:0] untR;  // Last unit index sent.
    logic [7:0] finR;  // Last final index sent.

    // Undriven reply lines show the inverse of their last value.
    assign instr    = respValid ? insR : ~insR;
    assign unitIdx  = respValid ? untR : ~untR;
    assign finalIdx = respValid ? finR : ~finR;

    // The card answers each command with one reply and sends an unasked instruction on a kick.
    always @(posedge clk) begin
        respValid <= 1'h0;
        if (reset) begin
            pend <= 1'h0;
        end else if (kick) begin
            respValid <= 1'h1;
            insR      <= kickInstr;
            untR      <= 8'h00;
            finR      <= 8'h00;
        end else if (cmdValid) begin
            pend  <= 1'h1;
            cnt   <= slow ? 4'h6 : 4'h1;
            codeR <= cmdCode;
            reqR  <= cmdUnitIndex;
        end else if (pend && cnt == 4'h0) begin
            pend      <= 1'h0;
            respValid <= 1'h1;
            insR      <= CSC_INS_NONE;
            untR      <= (codeR == CSC_CMD_CENTER) ? CSC_UNIT_FIRST : reqR + {7'h00, badUnit};
            finR      <= (codeR == CSC_CMD_REPORT) ? 8'h00 : finalCfg;
        end else if (pend) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule

//--- tb/csc_controller_bench.sv
`timescale 1ns/1ps
module csc_controller_bench;
    import csc_pkg::*;
    logic       clk, reset, kick, badUnit, slow;
    logic [8:0] ev;        // Event inputs, one bit each.
    logic [1:0] kickInstr, cardInstr, cmdStatus_ff;
    logic [7:0] finalCfg, respUnitIndex, respFinalIndex, cmdUnitIndex_ff;
    logic       cardRespValid, dialStart_ff, hangUp_ff, cmdValid_ff, forwardToCenter_ff, purchaseDisable_ff;
    csc_state_t sessionState_ff;
    csc_cmd_t   cmdCode_ff;
    int         mismatches, totalChecks;

    csc_controller dut (.clk(clk), .reset(reset), .cardRespValid(cardRespValid), .cardInstr(cardInstr),
        .respUnitIndex(respUnitIndex), .respFinalIndex(respFinalIndex), .modemConnected(ev[0]),
        .modemBusy(ev[1]), .cardError(ev[2]), .cardAbsent(ev[3]), .lineFault(ev[4]), .carrierLost(ev[5]),
        .respTimeout(ev[6]), .centerTimeout(ev[7]), .centerDataValid(ev[8]),
        .sessionState_ff(sessionState_ff), .dialStart_ff(dialStart_ff), .hangUp_ff(hangUp_ff),
        .cmdValid_ff(cmdValid_ff), .cmdCode_ff(cmdCode_ff), .cmdStatus_ff(cmdStatus_ff),
        .cmdUnitIndex_ff(cmdUnitIndex_ff), .forwardToCenter_ff(forwardToCenter_ff),
        .purchaseDisable_ff(purchaseDisable_ff));

    csc_card_model card_i (.clk(clk), .reset(reset), .cmdValid(cmdValid_ff), .cmdCode(cmdCode_ff),
        .cmdUnitIndex(cmdUnitIndex_ff), .kick(kick), .kickInstr(kickInstr), .finalCfg(finalCfg),
        .badUnit(badUnit), .slow(slow), .respValid(cardRespValid), .instr(cardInstr),
        .unitIdx(respUnitIndex), .finalIdx(respFinalIndex));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        totalChecks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // Raises one event input for a single cycle.
    task automatic pulse(int k);
        ev[k] = 1'h1;
        tick();
        ev[k] = 1'h0;
    endtask
    // Makes the card send an instruction; the controller has acted on return.
    task automatic card(logic [1:0] ins);
        kickInstr = ins;
        kick = 1'h1;
        tick();
        kick = 1'h0;
        tick();
    endtask
    // Lets the card answer the last command.
    task automatic settle();
        repeat (10) tick();
    endtask
    // Waits a bounded time for one command and checks its fields.
    task automatic waitCmd(logic [1:0] code, logic [1:0] st, logic [7:0] unit);
        for (int i = 0; i < 20 && cmdValid_ff !== 1'h1; i++) tick();
        if (cmdValid_ff !== 1'h1) begin
            chk("cmdValid", 8'h01, 8'h00);
            finish_test();
        end
        chk("cmdCode", {6'h00, code}, {6'h00, cmdCode_ff});
        chk("cmdStatus", {6'h00, st}, {6'h00, cmdStatus_ff});
        chk("cmdUnit", unit, cmdUnitIndex_ff);
        tick();
    endtask
    // Waits for forwarding with no further data request on the way.
    task automatic waitFwd();
        for (int i = 0; i < 20 && forwardToCenter_ff !== 1'h1; i++) begin
            if (cmdValid_ff === 1'h1 && cmdCode_ff === CSC_CMD_REQDATA) chk("extra request", 8'h00, 8'h01);
            tick();
        end
        if (forwardToCenter_ff !== 1'h1) begin
            chk("forward", 8'h01, 8'h00);
            finish_test();
        end
        tick();
    endtask
    task automatic goComm();
        card(CSC_INS_START);
        chk("dialStart", 8'h01, {7'h00, dialStart_ff});
        chk("state call-in", CSC_CALLIN, sessionState_ff);
        pulse(0);
        chk("state comm", CSC_COMM, sessionState_ff);
        chk("purchase enabled", 8'h00, {7'h00, purchaseDisable_ff});
        waitCmd(CSC_CMD_REPORT, CSC_ST_CONNECTED, 8'h00);
        settle();
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic testReset();
        chk("state reset", CSC_IDLE, sessionState_ff);
        chk("cmdValid reset", 8'h00, {7'h00, cmdValid_ff});
        chk("purchase reset", 8'h00, {7'h00, purchaseDisable_ff});
        pulse(2);
        chk("purchase disabled", 8'h01, {7'h00, purchaseDisable_ff});
        chk("card error idle", CSC_IDLE, sessionState_ff);
    endtask
    task automatic testFail();
        int ks[3] = '{1, 4, 5};
        card(CSC_INS_DISCONNECT);
        chk("idle disconnect", CSC_IDLE, sessionState_ff);
        chk("idle hangUp", 8'h00, {7'h00, hangUp_ff});
        foreach (ks[j]) begin
            goComm();
            card(CSC_INS_DISCONNECT);
            chk("comm disconnect", CSC_IDLE, sessionState_ff);
            card(CSC_INS_START);
            pulse(ks[j]);
            chk("fail state", CSC_IDLE, sessionState_ff);
            waitCmd(CSC_CMD_REPORT, CSC_ST_FAILED, 8'h00);
            settle();
        end
        card(CSC_INS_START);
        card(CSC_INS_DISCONNECT);
        chk("abort state", CSC_IDLE, sessionState_ff);
        chk("abort hangUp", 8'h01, {7'h00, hangUp_ff});
    endtask
    task automatic testTransfer();
        goComm();
        finalCfg = 8'h02;
        pulse(8);
        waitCmd(CSC_CMD_CENTER, CSC_ST_NONE, 8'h00);
        waitCmd(CSC_CMD_REQDATA, CSC_ST_NONE, 8'h02);
        waitFwd();
        settle();
        slow = 1'h1;
        finalCfg = 8'h00;
        pulse(8);
        waitCmd(CSC_CMD_CENTER, CSC_ST_NONE, 8'h00);
        waitFwd();
        slow = 1'h0;
        card(CSC_INS_DISCONNECT);
        chk("hangup state", CSC_IDLE, sessionState_ff);
        chk("hangup pulse", 8'h01, {7'h00, hangUp_ff});
    endtask
    task automatic testErrors();
        for (int k = 2; k < 8; k++) begin
            goComm();
            pulse(k);
            chk("error state", CSC_IDLE, sessionState_ff);
            chk("error hangUp", 8'h01, {7'h00, hangUp_ff});
            waitCmd(CSC_CMD_REPORT, CSC_ST_DISCONNECTED, 8'h00);
            settle();
        end
        goComm();
        badUnit = 1'h1;
        finalCfg = 8'h02;
        pulse(8);
        waitCmd(CSC_CMD_CENTER, CSC_ST_NONE, 8'h00);
        waitCmd(CSC_CMD_REQDATA, CSC_ST_NONE, 8'h02);
        waitCmd(CSC_CMD_REPORT, CSC_ST_DISCONNECTED, 8'h00);
        chk("unit error state", CSC_IDLE, sessionState_ff);
        badUnit = 1'h0;
        settle();
    endtask

    // Free-running 50 MHz clock.
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    // Reset for three cycles, then the scenarios in turn.
    initial begin
        reset = 1'h1;
        ev = 9'h000;
        kick = 1'h0;
        kickInstr = 2'h0;
        finalCfg = 8'h00;
        badUnit = 1'h0;
        slow = 1'h0;
        mismatches = 0;
        totalChecks = 0;
        repeat (3) @(posedge clk);
        #1;
        reset = 1'h0;
        tick();
        testReset();
        testFail();
        testTransfer();
        testErrors();
        finish_test();
    end
endmodule
